// File: rtl/bcb_pkg.sv
// Constants, encodings and carrier types for the bit-clear and branch executor.
// Assumes a 16-bit instruction word, a 21-bit program counter and a 12-bit data space.
package bcb_pkg;

   // widths
   localparam int PC_W    = 21;
   localparam int DADDR_W = 12;
   localparam int INSTR_W = 16;
   localparam int REG_AW  = 8;
   localparam int REG_DW  = 32;

   // instruction fields
   localparam int          BITCLR_TOP_POS  = 12;
   localparam logic [3:0]  BITCLR_TOP      = 4'h9;
   localparam int          BIT_IDX_POS     = 9;
   localparam int          BANK_SEL_POS    = 8;
   localparam int          UPPER_BYTE_POS  = 8;
   localparam logic [7:0]  OPC_BR_NEG      = 8'hE6;
   localparam logic [7:0]  OPC_BR_NO_CARRY = 8'hE3;
   localparam logic [7:0]  OPC_BR_NOT_NEG  = 8'hE7;
   localparam logic [7:0]  OPC_BR_NO_OVF   = 8'hE5;
   localparam logic [7:0]  OPC_BR_NONZERO  = 8'hE1;

   // addressing
   localparam logic [7:0]  IDX_LIMIT       = 8'h5F;
   localparam logic [3:0]  ACCESS_LOW_PAGE = 4'h0;
   localparam logic [3:0]  ACCESS_HI_PAGE  = 4'hF;
   localparam int          ACCESS_HI_POS   = 7;
   localparam logic [PC_W-1:0] PC_STEP     = 21'h00_0002;

   // register offsets
   localparam logic [REG_AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [REG_AW-1:0] OFS_BANK   = 8'h04;
   localparam logic [REG_AW-1:0] OFS_STATUS = 8'h08;
   localparam logic [REG_AW-1:0] OFS_TARGET = 8'h0C;

   // field positions and reset values
   localparam int          CTRL_EXT_POS     = 0;
   localparam int          STAT_BUSY_POS    = 0;
   localparam int          STAT_TAKEN_POS   = 1;
   localparam int          STAT_NOP_POS     = 2;
   localparam int          STAT_PHASE_POS   = 4;
   localparam logic        EXT_RESET        = 1'b0;
   localparam logic [3:0]  BANK_RESET       = 4'h0;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bcb_phase_type;
   typedef enum logic [1:0] {OP_NONE, OP_BITCLR, OP_BRANCH} bcb_op_type;
   typedef enum logic [2:0] {
      BR_NEG, BR_NO_CARRY, BR_NOT_NEG, BR_NO_OVF, BR_NONZERO
   } bcb_cond_type;

   typedef struct packed {
      logic negative;
      logic overflow;
      logic zero;
      logic carry;
   } bcb_flags_type;

   typedef struct packed {
      logic               rdEn;
      logic               wrEn;
      logic [DADDR_W-1:0] addr;
      logic [7:0]         wrData;
   } bcb_mem_req_type;

endpackage

// File: rtl/bcb_addr_resolve.sv
// Data-address former for the bit-clear operand.
// Assumes bank pointer and index base are stable while the instruction runs.
`timescale 1ns/1ps
module bcb_addr_resolve (
   // operand
   input  wire logic [7:0]                  fileAddr,
   input  wire logic                        bankSel,
   // mode and bases
   input  wire logic                        extEnable,
   input  wire logic [3:0]                  bankPtr,
   input  wire logic [bcb_pkg::DADDR_W-1:0] idxBase,
   // result
   output logic      [bcb_pkg::DADDR_W-1:0] dataAddr,
   output logic                             idxMode
);

   // indexed literal offset only in the low part of the quick-access bank
   assign idxMode = extEnable && !bankSel && (fileAddr <= bcb_pkg::IDX_LIMIT);

   // pick one of four address forms
   always_comb begin
      if (idxMode) begin
         dataAddr = idxBase + {4'h0, fileAddr};
      end else if (bankSel) begin
         dataAddr = {bankPtr, fileAddr};
      end else if (fileAddr[bcb_pkg::ACCESS_HI_POS]) begin
         dataAddr = {bcb_pkg::ACCESS_HI_PAGE, fileAddr};
      end else begin
         dataAddr = {bcb_pkg::ACCESS_LOW_PAGE, fileAddr};
      end
   end

endmodule

// File: rtl/bcb_branch_target.sv
// Relative branch target adder.
// Assumes instrAddr is the address of the branch word itself.
`timescale 1ns/1ps
module bcb_branch_target (
   // inputs
   input  wire logic [bcb_pkg::PC_W-1:0] instrAddr,
   input  wire logic [7:0]               offset,
   // result
   output logic      [bcb_pkg::PC_W-1:0] target
);

   logic [bcb_pkg::PC_W-1:0] twiceOffset;

   // sign extend and double; wraps modulo the counter width
   assign twiceOffset = {{(bcb_pkg::PC_W - 9){offset[7]}}, offset, 1'b0};
   assign target      = instrAddr + bcb_pkg::PC_STEP + twiceOffset;

endmodule

// File: rtl/bcb_exec.sv
// Decode and execute for bit-clear and five conditional relative branches.
// Assumes fetch, flags and data memory share this clock; memory answers a read in the cycle its strobe stands.
//
// Contract
// - bit-clear zeroes indexed bit, keeps others
// - bank bit 0 selects quick-access bank
// - bank bit 1 uses bank pointer
// - extended mode, low file: indexed offset
// - negative branch taken when negative set
// - upper byte E6 decodes negative branch
// - no-carry branch taken when carry clear
// - upper byte E3 decodes no-carry branch
// - not-negative branch taken when negative clear
// - upper byte E7 decodes not-negative branch
// - E5 branch taken when overflow clear
// - E1 branch taken when zero clear
// - offset signed, doubled, added to counter
// - target is address plus two plus 2n
// - branch one cycle, two when taken
`timescale 1ns/1ps
module bcb_exec (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          resetn,
   // software register port
   input  wire logic [bcb_pkg::REG_AW-1:0]    regAddr,
   input  wire logic [bcb_pkg::REG_DW-1:0]    regWrData,
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   output logic      [bcb_pkg::REG_DW-1:0]    regRdData,
   // instruction fetch
   input  wire logic [bcb_pkg::INSTR_W-1:0]   instrWord,
   input  wire logic                          instrValid,
   input  wire logic [bcb_pkg::PC_W-1:0]      instrAddr,
   output logic                               instrTake,
   output logic                               flushFetch,
   // program counter
   output logic                               pcLoad,
   output logic      [bcb_pkg::PC_W-1:0]      pcTarget,
   // status flags
   input  wire bcb_pkg::bcb_flags_type        flagsIn,
   output logic                               statusWrite,
   // data memory
   input  wire logic [bcb_pkg::DADDR_W-1:0]   idxBase,
   output bcb_pkg::bcb_mem_req_type           memReq,
   input  wire logic [7:0]                    memRdData
);

   // phase and instruction state
   bcb_pkg::bcb_phase_type      phase_ff;
   bcb_pkg::bcb_phase_type      nxt_phase;
   bcb_pkg::bcb_op_type         opKind_ff;
   bcb_pkg::bcb_op_type         nxt_opKind;
   bcb_pkg::bcb_cond_type       cond_ff;
   bcb_pkg::bcb_cond_type       nxt_cond;
   logic [bcb_pkg::INSTR_W-1:0] instr_ff;
   logic [bcb_pkg::PC_W-1:0]    instrAddr_ff;
   logic                        nopCycle_ff;
   logic                        taken_ff;
   logic [7:0]                  modData_ff;

   // software visible state
   logic                        extEnable_ff;
   logic [3:0]                  bankPtr_ff;
   logic                        lastTaken_ff;
   logic [bcb_pkg::REG_DW-1:0]  regRdData_ff;

   // outputs held in flops
   logic                        pcLoad_ff;
   logic [bcb_pkg::PC_W-1:0]    pcTarget_ff;
   bcb_pkg::bcb_mem_req_type    memReq_ff;

   // decode and datapath helpers
   logic [2:0]                  bitIdx;
   logic                        bankSel;
   logic [7:0]                  fileAddr;
   logic [7:0]                  offsetField;
   logic [7:0]                  upperByte;
   logic [7:0]                  clearMask;
   logic [bcb_pkg::DADDR_W-1:0] resolvedAddr;
   logic                        idxMode;
   logic [bcb_pkg::PC_W-1:0]    branchTarget;
   logic                        condMet;
   logic                        startNew;
   logic                        takenSet;
   logic                        takenClr;

   // fields of the instruction latched at the first phase; upperByte comes from the incoming word
   assign bitIdx      = instr_ff[bcb_pkg::BIT_IDX_POS +: 3];
   assign bankSel     = instr_ff[bcb_pkg::BANK_SEL_POS];
   assign fileAddr    = instr_ff[7:0];
   assign offsetField = instr_ff[7:0];
   assign upperByte   = instrWord[bcb_pkg::UPPER_BYTE_POS +: 8];

   // fetch handshake: take a word at Q1 unless the slot is a discard cycle
   assign startNew   = (phase_ff == bcb_pkg::PH_Q1) && instrValid && !nopCycle_ff;
   assign instrTake  = (phase_ff == bcb_pkg::PH_Q1) && !nopCycle_ff;
   assign flushFetch = nopCycle_ff;

   // flags are only ever read here
   assign statusWrite = 1'b0;

   assign pcLoad    = pcLoad_ff;
   assign pcTarget  = pcTarget_ff;
   assign memReq    = memReq_ff;
   assign regRdData = regRdData_ff;

   // operand address for the bit-clear
   bcb_addr_resolve u_addr (
      .fileAddr  (fileAddr),
      .bankSel   (bankSel),
      .extEnable (extEnable_ff),
      .bankPtr   (bankPtr_ff),
      .idxBase   (idxBase),
      .dataAddr  (resolvedAddr),
      .idxMode   (idxMode)
   );

   // relative target from the branch word's own address
   bcb_branch_target u_target (
      .instrAddr (instrAddr_ff),
      .offset    (offsetField),
      .target    (branchTarget)
   );

   // four-phase instruction cycle, one clock per phase
   always_comb begin
      case (phase_ff)
         bcb_pkg::PH_Q1: nxt_phase = bcb_pkg::PH_Q2;
         bcb_pkg::PH_Q2: nxt_phase = bcb_pkg::PH_Q3;
         bcb_pkg::PH_Q3: nxt_phase = bcb_pkg::PH_Q4;
         bcb_pkg::PH_Q4: nxt_phase = bcb_pkg::PH_Q1;
         default:        nxt_phase = bcb_pkg::PH_Q1;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         phase_ff <= bcb_pkg::PH_Q1;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // decode of the incoming word; other opcodes belong to other units
   always_comb begin
      nxt_opKind = bcb_pkg::OP_NONE;
      nxt_cond   = bcb_pkg::BR_NEG;
      if (instrWord[bcb_pkg::BITCLR_TOP_POS +: 4] == bcb_pkg::BITCLR_TOP) begin
         nxt_opKind = bcb_pkg::OP_BITCLR;
      end else begin
         case (upperByte)
            bcb_pkg::OPC_BR_NEG: begin
               nxt_opKind = bcb_pkg::OP_BRANCH;
               nxt_cond   = bcb_pkg::BR_NEG;
            end
            bcb_pkg::OPC_BR_NO_CARRY: begin
               nxt_opKind = bcb_pkg::OP_BRANCH;
               nxt_cond   = bcb_pkg::BR_NO_CARRY;
            end
            bcb_pkg::OPC_BR_NOT_NEG: begin
               nxt_opKind = bcb_pkg::OP_BRANCH;
               nxt_cond   = bcb_pkg::BR_NOT_NEG;
            end
            bcb_pkg::OPC_BR_NO_OVF: begin
               nxt_opKind = bcb_pkg::OP_BRANCH;
               nxt_cond   = bcb_pkg::BR_NO_OVF;
            end
            bcb_pkg::OPC_BR_NONZERO: begin
               nxt_opKind = bcb_pkg::OP_BRANCH;
               nxt_cond   = bcb_pkg::BR_NONZERO;
            end
            default: begin
               nxt_opKind = bcb_pkg::OP_NONE;
               nxt_cond   = bcb_pkg::BR_NEG;
            end
         endcase
      end
   end

   // latch instruction at Q1; kind drops back to none at the end of Q4
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         opKind_ff    <= bcb_pkg::OP_NONE;
         cond_ff      <= bcb_pkg::BR_NEG;
         instr_ff     <= 16'h0000;
         instrAddr_ff <= 21'h00_0000;
      end else if (startNew) begin
         opKind_ff    <= nxt_opKind;
         cond_ff      <= nxt_cond;
         instr_ff     <= instrWord;
         instrAddr_ff <= instrAddr;
      end else if (phase_ff == bcb_pkg::PH_Q4) begin
         opKind_ff    <= bcb_pkg::OP_NONE;
      end
   end

   // branch condition against the live flags
   always_comb begin
      case (cond_ff)
         bcb_pkg::BR_NEG:      condMet = flagsIn.negative;
         bcb_pkg::BR_NO_CARRY: condMet = !flagsIn.carry;
         bcb_pkg::BR_NOT_NEG:  condMet = !flagsIn.negative;
         bcb_pkg::BR_NO_OVF:   condMet = !flagsIn.overflow;
         bcb_pkg::BR_NONZERO:  condMet = !flagsIn.zero;
         default:              condMet = 1'b0;
      endcase
   end

   // condition sampled in Q3 so flags written by the previous Q4 are seen
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         taken_ff <= 1'b0;
      end else if (phase_ff == bcb_pkg::PH_Q3) begin
         taken_ff <= (opKind_ff == bcb_pkg::OP_BRANCH) && condMet;
      end else if (phase_ff == bcb_pkg::PH_Q1) begin
         taken_ff <= 1'b0;
      end
   end

   // counter load: one-clock pulse after Q4 of a taken branch
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pcLoad_ff   <= 1'b0;
         pcTarget_ff <= 21'h00_0000;
      end else if ((phase_ff == bcb_pkg::PH_Q4) && taken_ff) begin
         pcLoad_ff   <= 1'b1;
         pcTarget_ff <= branchTarget;
      end else begin
         pcLoad_ff   <= 1'b0;
      end
   end

   // discard cycle: the word already fetched behind a taken branch is dropped
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nopCycle_ff <= 1'b0;
      end else if (phase_ff == bcb_pkg::PH_Q4) begin
         nopCycle_ff <= taken_ff && !nopCycle_ff;
      end
   end

   // single-bit clear mask, one generate lane per data bit
   for (genvar gi = 0; gi < 8; gi++) begin : g_mask
      assign clearMask[gi] = (bitIdx != gi[2:0]);
   end

   // read in Q2, modify in Q3, write back in Q4
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         memReq_ff  <= '0;
         modData_ff <= 8'h00;
      end else begin
         memReq_ff.rdEn <= 1'b0;
         memReq_ff.wrEn <= 1'b0;
         if (opKind_ff == bcb_pkg::OP_BITCLR) begin
            case (phase_ff)
               bcb_pkg::PH_Q2: begin
                  memReq_ff.addr <= resolvedAddr;
                  memReq_ff.rdEn <= 1'b1;
               end
               bcb_pkg::PH_Q3: begin
                  modData_ff <= memRdData & clearMask;
               end
               bcb_pkg::PH_Q4: begin
                  memReq_ff.wrEn   <= 1'b1;
                  memReq_ff.wrData <= modData_ff;
               end
               default: begin
                  memReq_ff.rdEn <= 1'b0;
               end
            endcase
         end
      end
   end

   // control registers written by software
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         extEnable_ff <= bcb_pkg::EXT_RESET;
         bankPtr_ff   <= bcb_pkg::BANK_RESET;
      end else if (regWrite) begin
         if (regAddr == bcb_pkg::OFS_CTRL) begin
            extEnable_ff <= regWrData[bcb_pkg::CTRL_EXT_POS];
         end
         if (regAddr == bcb_pkg::OFS_BANK) begin
            bankPtr_ff <= regWrData[3:0];
         end
      end
   end

   // sticky taken flag; a new taken branch beats a software clear
   assign takenSet = pcLoad_ff;
   assign takenClr = regWrite && (regAddr == bcb_pkg::OFS_STATUS)
                     && regWrData[bcb_pkg::STAT_TAKEN_POS];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lastTaken_ff <= 1'b0;
      end else if (takenSet) begin
         lastTaken_ff <= 1'b1;
      end else if (takenClr) begin
         lastTaken_ff <= 1'b0;
      end
   end

   // read data valid the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         regRdData_ff <= 32'h0000_0000;
      end else if (regRead) begin
         regRdData_ff <= 32'h0000_0000;
         case (regAddr)
            bcb_pkg::OFS_CTRL: begin
               regRdData_ff[bcb_pkg::CTRL_EXT_POS] <= extEnable_ff;
            end
            bcb_pkg::OFS_BANK: begin
               regRdData_ff[3:0] <= bankPtr_ff;
            end
            bcb_pkg::OFS_STATUS: begin
               regRdData_ff[bcb_pkg::STAT_BUSY_POS]      <= (opKind_ff != bcb_pkg::OP_NONE);
               regRdData_ff[bcb_pkg::STAT_TAKEN_POS]     <= lastTaken_ff;
               regRdData_ff[bcb_pkg::STAT_NOP_POS]       <= nopCycle_ff;
               regRdData_ff[bcb_pkg::STAT_PHASE_POS +: 2] <= phase_ff;
            end
            bcb_pkg::OFS_TARGET: begin
               regRdData_ff[bcb_pkg::PC_W-1:0] <= pcTarget_ff;
            end
            default: begin
               regRdData_ff <= 32'h0000_0000;
            end
         endcase
      end else begin
         regRdData_ff <= 32'h0000_0000;
      end
   end

endmodule

// File: sim/bcb_exec_properties.sv
// Concurrent checks on the ports of the bit-clear and branch executor.
// Assumes it is bound to bcb_exec and sees nothing but its ports.
`timescale 1ns/1ps
module bcb_exec_properties (
   // clock and reset
   input wire logic                        clock,
   input wire logic                        resetn,
   // fetch and counter
   input wire logic [bcb_pkg::INSTR_W-1:0] instrWord,
   input wire logic                        instrValid,
   input wire logic [bcb_pkg::PC_W-1:0]    instrAddr,
   input wire logic                        instrTake,
   input wire logic                        flushFetch,
   input wire logic                        pcLoad,
   input wire logic [bcb_pkg::PC_W-1:0]    pcTarget,
   // flags and memory
   input wire bcb_pkg::bcb_flags_type      flagsIn,
   input wire logic                        statusWrite,
   input wire bcb_pkg::bcb_mem_req_type    memReq,
   input wire logic [7:0]                  memRdData
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   logic take;
   logic isClr;
   logic isBr;
   // a word counts only on the edge the executor accepts it
   assign take  = instrTake && instrValid;
   assign isClr = take && (instrWord[15:12] == bcb_pkg::BITCLR_TOP);
   assign isBr  = take && (instrWord[15:8] inside {bcb_pkg::OPC_BR_NEG,
      bcb_pkg::OPC_BR_NO_CARRY, bcb_pkg::OPC_BR_NOT_NEG, bcb_pkg::OPC_BR_NO_OVF,
      bcb_pkg::OPC_BR_NONZERO});

   // branch condition, written apart from the design
   function automatic logic brGo(logic [7:0] op, bcb_pkg::bcb_flags_type f);
      case (op)
         bcb_pkg::OPC_BR_NEG:      return f.negative;
         bcb_pkg::OPC_BR_NO_CARRY: return !f.carry;
         bcb_pkg::OPC_BR_NOT_NEG:  return !f.negative;
         bcb_pkg::OPC_BR_NO_OVF:   return !f.overflow;
         default:                  return !f.zero;
      endcase
   endfunction

   property p_clr_seq;
      isClr |-> ##2 memReq.rdEn ##1 !memReq.rdEn ##1 memReq.wrEn;
   endproperty
   a_clr_seq: assert property (p_clr_seq) else $error("bit-clear phases out of step");
   property p_clr_data;
      isClr |-> ##4 memReq.wrData ==
         ($past(memRdData, 2) & ~(8'h01 << $past(instrWord[11:9], 4)));
   endproperty
   a_clr_data: assert property (p_clr_data) else $error("bit-clear data wrong");
   property p_clr_hi;
      isClr && !instrWord[8] && instrWord[7] |->
         ##2 memReq.addr == {bcb_pkg::ACCESS_HI_PAGE, $past(instrWord[7:0], 2)};
   endproperty
   a_clr_hi: assert property (p_clr_hi) else $error("upper access address wrong");
   property p_clr_lo;
      isClr && !instrWord[8] && instrWord[7:5] == 3'b011 |->
         ##2 memReq.addr == {4'h0, $past(instrWord[7:0], 2)};
   endproperty
   a_clr_lo: assert property (p_clr_lo) else $error("lower access address wrong");
   property p_br_go;
      isBr |-> ##4 (pcLoad == brGo($past(instrWord[15:8], 4), $past(flagsIn, 2))
         && instrTake == !pcLoad);
   endproperty
   a_br_go: assert property (p_br_go) else $error("branch decision wrong");
   property p_br_target;
      isBr |-> ##4 (!pcLoad || pcTarget == $past(instrAddr, 4) + 21'h00_0002
         + {{12{$past(instrWord[7], 4)}}, $past(instrWord[7:0], 4), 1'b0});
   endproperty
   a_br_target: assert property (p_br_target) else $error("branch target wrong");
   property p_flush;
      pcLoad |-> (flushFetch && !instrTake) [*4] ##1 (!flushFetch && instrTake);
   endproperty
   a_flush: assert property (p_flush) else $error("discard cycle wrong");
   property p_no_status;
      statusWrite == 1'b0;
   endproperty
   a_no_status: assert property (p_no_status) else $error("status written");

   c_clr: cover property (isClr ##4 memReq.wrEn);
   c_taken: cover property (isBr ##4 pcLoad);
   c_not_taken: cover property (isBr ##4 !pcLoad);
endmodule

bind bcb_exec bcb_exec_properties u_props (
   .clock(clock), .resetn(resetn), .instrWord(instrWord), .instrValid(instrValid),
   .instrAddr(instrAddr), .instrTake(instrTake), .flushFetch(flushFetch),
   .pcLoad(pcLoad), .pcTarget(pcTarget), .flagsIn(flagsIn), .statusWrite(statusWrite),
   .memReq(memReq), .memRdData(memRdData)
);

// File: sim/bcb_mem_model.sv
// Data memory standing beside the executor.
// Assumes reads are answered in the cycle the read strobe stands.
`timescale 1ns/1ps
module bcb_mem_model (
   // clock
   input wire logic                     clock,
   // request and answer
   input wire bcb_pkg::bcb_mem_req_type memReq,
   output logic [7:0]                   memRdData
);
   logic [7:0] store [0:4095];
   logic [7:0] lastData;

   // preset contents so neighbouring bytes differ
   initial begin
      for (int i = 0; i < 4096; i++) begin
         store[i] = 8'(i * 37 + 90);
      end
      lastData = 8'h00;
   end
   // outside a read show the inverse, so a late sample cannot pass by luck
   assign memRdData = memReq.rdEn ? store[memReq.addr] : ~lastData;
   // write back and remember the last answer
   always @(posedge clock) begin
      if (memReq.rdEn) lastData <= store[memReq.addr];
      if (memReq.wrEn) store[memReq.addr] <= memReq.wrData;
   end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the bit-clear and branch executor.
// Assumes the memory model answers reads and the checker is bound.
`timescale 1ns/1ps
module testbench;
   // clock, reset and register port
   logic        clock;
   logic        resetn;
   logic [7:0]  regAddr;
   logic [31:0] regWrData;
   logic        regWrite;
   logic        regRead;
   logic [31:0] regRdData;
   // fetch, counter, flags, memory
   logic [15:0] instrWord;
   logic        instrValid;
   logic [20:0] instrAddr;
   logic        instrTake;
   logic        flushFetch;
   logic        pcLoad;
   logic [20:0] pcTarget;
   logic        statusWrite;
   logic [11:0] idxBase;
   logic [7:0]  memRdData;
   bcb_pkg::bcb_flags_type   flagsIn;
   bcb_pkg::bcb_mem_req_type memReq;
   // bench model state
   int          failures;
   int          checkCount;
   int          expMem [int];
   logic        extOn;
   logic [3:0]  bankVal;
   logic [7:0]  ops [5];

   bcb_exec DUT (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .instrWord(instrWord),
      .instrValid(instrValid), .instrAddr(instrAddr), .instrTake(instrTake),
      .flushFetch(flushFetch), .pcLoad(pcLoad), .pcTarget(pcTarget), .flagsIn(flagsIn),
      .statusWrite(statusWrite), .idxBase(idxBase), .memReq(memReq), .memRdData(memRdData));
   bcb_mem_model u_mem (.clock(clock), .memReq(memReq), .memRdData(memRdData));

   // 40 ns core clock
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && checkCount > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      check("regRdData", regRdData, e);
   endtask

   // hold the word until an edge with instrTake high accepts it
   task automatic issue(input logic [15:0] w, input logic [20:0] a,
                        input bcb_pkg::bcb_flags_type fl);
      int k;
      @(posedge clock);
      instrWord <= w;
      instrAddr <= a;
      flagsIn <= fl;
      instrValid <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (instrTake === 1'b1) break;
      end
      check("instrTake", k < 20, 1);
      instrValid <= 1'b0;
   endtask

   task automatic do_clr(input logic [2:0] b, input logic a, input logic [7:0] f);
      int ad;
      logic [7:0] nv;
      if (a) ad = bankVal * 256 + f;
      else if (extOn && f <= 8'h5F) ad = (int'(idxBase) + f) % 4096;
      else if (f[7]) ad = 3840 + f;
      else ad = f;
      nv = expMem.exists(ad) ? expMem[ad] : 8'(ad * 37 + 90);
      nv = nv & ~(8'h01 << b);
      issue({4'h9, b, a, f}, 21'($urandom) & 21'h1F_FFFE, 4'($urandom));
      @(posedge clock);
      @(negedge clock);
      check("rdEn", memReq.rdEn, 1);
      check("addr", memReq.addr, ad);
      repeat (2) @(posedge clock);
      @(negedge clock);
      check("wrEn", memReq.wrEn, 1);
      check("wrData", memReq.wrData, nv);
      check("statusWrite", statusWrite, 0);
      expMem[ad] = nv;
   endtask

   task automatic do_br(input logic [7:0] op, input logic [7:0] n,
                        input bcb_pkg::bcb_flags_type fl, input logic [20:0] pc);
      logic go;
      logic [20:0] t;
      case (op)
         bcb_pkg::OPC_BR_NEG:      go = fl.negative;
         bcb_pkg::OPC_BR_NO_CARRY: go = !fl.carry;
         bcb_pkg::OPC_BR_NOT_NEG:  go = !fl.negative;
         bcb_pkg::OPC_BR_NO_OVF:   go = !fl.overflow;
         default:                  go = !fl.zero;
      endcase
      t = pc + 21'h00_0002 + {{12{n[7]}}, n, 1'b0};
      issue({op, n}, pc, fl);
      repeat (3) @(posedge clock);
      @(negedge clock);
      check("pcLoad", pcLoad, go);
      check("flushFetch", flushFetch, go);
      if (go) check("pcTarget", pcTarget, t);
   endtask

   // cut a hang short well past the expected run length
   initial begin
      #500_000;
      failures++;
      give_verdict();
   end

   // main sequence
   initial begin
      {resetn, regAddr, regWrData, regWrite, regRead, instrWord, instrValid} = '0;
      {instrAddr, idxBase, flagsIn, extOn, bankVal, failures, checkCount} = '0;
      ops = '{bcb_pkg::OPC_BR_NEG, bcb_pkg::OPC_BR_NO_CARRY, bcb_pkg::OPC_BR_NOT_NEG,
              bcb_pkg::OPC_BR_NO_OVF, bcb_pkg::OPC_BR_NONZERO};
      void'($urandom(32'h4a69));
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      reg_rd(bcb_pkg::OFS_CTRL, 0);
      reg_rd(bcb_pkg::OFS_BANK, 0);
      reg_rd(8'h10, 0);
      // each pass flips extended mode and picks a new bank and index base
      for (int i = 0; i < 4; i++) begin
         extOn = 1'(i);
         bankVal = 4'($urandom);
         reg_wr(bcb_pkg::OFS_CTRL, {31'h0, extOn});
         reg_wr(bcb_pkg::OFS_BANK, {28'h0, bankVal});
         reg_rd(bcb_pkg::OFS_BANK, {28'h0, bankVal});
         @(posedge clock);
         idxBase <= 12'($urandom);
         for (int j = 0; j < 12; j++) begin
            do_clr(3'($urandom), 1'($urandom),
               j[0] ? 8'($urandom) : 8'($urandom_range(8'h62, 8'h5C)));
         end
         for (int j = 0; j < 10; j++) begin
            do_br(ops[j % 5], j == 0 ? 8'h80 : (j == 1 ? 8'h7F : 8'($urandom)),
               4'($urandom), j == 2 ? 21'h1F_FFFE : 21'($urandom) & 21'h1F_FFFE);
         end
      end
      give_verdict();
   end
endmodule
